// ---- include/rvpp_pkg.sv ----
// package of constants and types for the receive video pixel packer
package rvpp_pkg;

  // ----------------------------------------
  // configuration defaults
  // ----------------------------------------
  localparam int MAX_COMPONENT_BITS_DEF = 16; // widest component field
  localparam int LANE_COUNT_DEF = 4; // lanes, and default slot count
  localparam int COMPONENTS_PER_PIXEL = 3; // colour components per pixel
  localparam int DEPTH_W = 5; // width of the video depth port
  localparam int MODE_W = 3; // width of the pixels-per-clock port

  // ----------------------------------------
  // pixels-per-clock encodings
  // ----------------------------------------
  localparam logic [2:0] MODE_ONE = 3'h1; // single pixel mode
  localparam logic [2:0] MODE_TWO = 3'h2; // dual pixel mode
  localparam logic [2:0] MODE_FOUR = 3'h4; // quad pixel mode

  // ----------------------------------------
  // reduced blanking limits
  // ----------------------------------------
  localparam int RB_BLANK_SHORT = 80; // first reduced blanking width
  localparam int RB_BLANK_LONG = 160; // second reduced blanking width
  localparam int RB_ACTIVE_ALIGN = 8; // active width granule
  localparam int RB_BLANK_PCT = 20; // blank share limit, percent
  localparam int PCT_SCALE = 100; // percent scale for the blank share

  // ----------------------------------------
  // packer state
  // ----------------------------------------
  typedef enum logic [1:0] {
    RVPP_IDLE = 2'b00,
    RVPP_LINE = 2'b01,
    RVPP_FLUSH = 2'b11
  } rvpp_state_t;

endpackage

// ---- logic/rvpp_packer.sv ----
// output pixel packer placing recovered pixels on a multi-pixel video stream
`timescale 1ns/1ns
// Function
// - pixel is three components of maximum width
// - bus holds one pixel slot per lane
// - mode defaults to lanes, software may override
// - mode one uses only slot zero
// - mode two uses slots zero and one
// - mode four uses all four slots ascending
// - pixel n at n times width, components consecutive
// - shallower video aligned to field top
// - low padding bits driven to zero
// - standard reduced blanking timings are recognised
// - end-of-line reset of a line of two or more beats pulses line_reset_o and holds input ready low a cycle, unless software sets the line reset disable

// slot n of the stream starts at bit n times the pixel width
// each flushed line costs one cycle of input ready
module rvpp_packer #(
  parameter int MAX_COMPONENT_BITS = rvpp_pkg::MAX_COMPONENT_BITS_DEF,
  parameter int LANES = rvpp_pkg::LANE_COUNT_DEF,
  parameter int PIX_W = MAX_COMPONENT_BITS * rvpp_pkg::COMPONENTS_PER_PIXEL,
  parameter int BUS_W = PIX_W * LANES,
  parameter int HW = 16
) (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // configuration
  input wire logic mode_override_i,
  input wire logic [rvpp_pkg::MODE_W-1:0] pixels_per_clock_i,
  input wire logic [rvpp_pkg::DEPTH_W-1:0] video_depth_i,
  input wire logic line_reset_disable_i,
  input wire logic [HW-1:0] horizontal_active_pixels_i,
  input wire logic [HW-1:0] horizontal_blank_pixels_i,
  input wire logic [HW-1:0] horizontal_total_pixels_i,
  // incoming pixels from the link datapath
  input wire logic [BUS_W-1:0] in_data_i,
  input wire logic in_valid_i,
  input wire logic in_sof_i,
  input wire logic in_eol_i,
  output logic in_ready_o,
  // outgoing video stream
  output logic [BUS_W-1:0] m_axis_tdata_o,
  output logic m_axis_tvalid_o,
  output logic m_axis_tuser_o,
  output logic m_axis_tlast_o,
  input wire logic m_axis_tready_i,
  // status
  output logic [rvpp_pkg::MODE_W-1:0] active_mode_o,
  output logic reduced_blanking_o,
  output logic line_reset_o
);

  // ----------------------------------------
  // mode selection
  // ----------------------------------------
  // lane count as a mode code, the mode after reset and without override
  localparam logic [rvpp_pkg::MODE_W-1:0] LANE_MODE = rvpp_pkg::MODE_W'(LANES);
  // software override wins only while it is enabled
  wire logic [rvpp_pkg::MODE_W-1:0] mode_sel; // effective pixels per clock
  assign mode_sel = mode_override_i ? pixels_per_clock_i : LANE_MODE;
  // left shift that lifts a shallow component to the top of its field
  // video deeper than the field passes unshifted, never shifted right
  wire logic [rvpp_pkg::DEPTH_W-1:0] pad_bits; // low padding per field
  assign pad_bits = (video_depth_i >= rvpp_pkg::DEPTH_W'(MAX_COMPONENT_BITS)) ? '0 :
    rvpp_pkg::DEPTH_W'(MAX_COMPONENT_BITS) - video_depth_i;

  // ----------------------------------------
  // per-slot, per-component placement
  // ----------------------------------------
  // all slots are built side by side; slots above the mode read as zero
  logic [BUS_W-1:0] packed_data; // combinational packed bus
  genvar s, c;
  generate
    for (s = 0; s < LANES; s++) begin : g_slot
      wire logic slot_on; // slot inside active mode
      assign slot_on = (s < int'(mode_sel));
      // three fields per slot, first component at the slot base
      for (c = 0; c < rvpp_pkg::COMPONENTS_PER_PIXEL; c++) begin : g_comp
        // base bit of this component within the whole bus
        localparam int LO = s * PIX_W + c * MAX_COMPONENT_BITS;
        wire logic [MAX_COMPONENT_BITS-1:0] raw; // value in low bits
        wire logic [MAX_COMPONENT_BITS-1:0] aligned; // msb aligned, zero pad
        // field as delivered, value in its low bits
        assign raw = in_data_i[LO +: MAX_COMPONENT_BITS];
        assign aligned = raw << pad_bits;
        assign packed_data[LO +: MAX_COMPONENT_BITS] = slot_on ? aligned : '0;
      end
    end
  endgenerate

  // ----------------------------------------
  // reduced blanking detection
  // ----------------------------------------
  // status only: software still drives the line reset disable itself
  wire logic blank_std; // blank is 80 or 160
  wire logic blank_share; // blank at most a fifth of total
  wire logic active_align; // active width multiple of eight
  assign blank_std = (horizontal_blank_pixels_i == HW'(rvpp_pkg::RB_BLANK_SHORT)) ||
    (horizontal_blank_pixels_i == HW'(rvpp_pkg::RB_BLANK_LONG));
  // operands widened by a byte so that a full-scale total cannot wrap
  assign blank_share = ({8'h00, horizontal_blank_pixels_i} * rvpp_pkg::PCT_SCALE) <=
    ({8'h00, horizontal_total_pixels_i} * rvpp_pkg::RB_BLANK_PCT);
  assign active_align = (horizontal_active_pixels_i % rvpp_pkg::RB_ACTIVE_ALIGN) == 0;

  // ----------------------------------------
  // output stage and line flush
  // ----------------------------------------
  // packer state and its next value
  rvpp_pkg::rvpp_state_t state; // packer state
  rvpp_pkg::rvpp_state_t next_state;
  wire logic out_free; // output register may load
  wire logic take; // input beat accepted
  // single output register; it may reload on the edge where it drains
  assign out_free = !m_axis_tvalid_o || m_axis_tready_i;
  // no beat is offered as taken while the clock enable freezes the block
  assign in_ready_o = clk_en_i && out_free && (state != rvpp_pkg::RVPP_FLUSH);
  assign take = in_valid_i && in_ready_o;
  // flush is skipped when software marks the timing as reduced blanking
  wire logic eol_flush; // end of line reset request
  assign eol_flush = take && in_eol_i && !line_reset_disable_i;

  // state step
  // idle waits for the first beat, so a one-beat line taken in idle never flushes
  always_comb begin
    next_state = state;
    unique case (state)
      rvpp_pkg::RVPP_IDLE: if (take) next_state = rvpp_pkg::RVPP_LINE;
      rvpp_pkg::RVPP_LINE: if (eol_flush) next_state = rvpp_pkg::RVPP_FLUSH;
      rvpp_pkg::RVPP_FLUSH: next_state = rvpp_pkg::RVPP_IDLE; // one-cycle flush
      default: next_state = rvpp_pkg::RVPP_IDLE;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // every register holds its value while the clock enable is low
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= rvpp_pkg::RVPP_IDLE;
      m_axis_tdata_o <= '0;
      m_axis_tvalid_o <= 1'b0;
      m_axis_tuser_o <= 1'b0;
      m_axis_tlast_o <= 1'b0;
      active_mode_o <= rvpp_pkg::MODE_W'(LANES);
      reduced_blanking_o <= 1'b0;
      line_reset_o <= 1'b0;
    end else if (clk_en_i) begin
      state <= next_state;
      active_mode_o <= mode_sel;
      reduced_blanking_o <= blank_std && blank_share && active_align;
      line_reset_o <= (state == rvpp_pkg::RVPP_LINE) && eol_flush;
      // load a new beat, else drain once the sink has taken it
      if (take) begin
        m_axis_tdata_o <= packed_data;
        m_axis_tvalid_o <= 1'b1;
        m_axis_tuser_o <= in_sof_i;
        m_axis_tlast_o <= in_eol_i;
      end else if (m_axis_tready_i) begin
        m_axis_tvalid_o <= 1'b0;
        m_axis_tdata_o <= '0; // flushed data does not linger
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // all checks share the block clock and are off during reset
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // mode one: nothing shows above slot zero
  chk_slot_zero_mode: assert property (clk_en_i && take && mode_sel == rvpp_pkg::MODE_ONE
    |=> m_axis_tdata_o[BUS_W-1:PIX_W] == '0) else $error("upper slots not zero");
  // mode two: nothing shows above slot one
  chk_slot_two_mode: assert property (clk_en_i && take && mode_sel == rvpp_pkg::MODE_TWO
    |=> m_axis_tdata_o[BUS_W-1:2*PIX_W] == '0) else $error("slots above one not zero");
  // a taken beat is offered on the very next cycle
  chk_take_answer: assert property (clk_en_i && take
    |=> m_axis_tvalid_o) else $error("taken beat not offered");
  // end-of-line reset is a single-cycle pulse
  chk_reset_flush: assert property (clk_en_i && state == rvpp_pkg::RVPP_LINE && eol_flush
    |=> line_reset_o ##1 !line_reset_o) else $error("line reset not one pulse");
  // no beat enters during the flush cycle
  chk_flush_blocks: assert property (state == rvpp_pkg::RVPP_FLUSH |-> !in_ready_o)
    else $error("input taken during flush");
  // a steady disable suppresses the line reset
  chk_reset_disabled: assert property (line_reset_disable_i && $stable(line_reset_disable_i)
    |-> !line_reset_o) else $error("line reset while disabled");
  // reset default and no override give the lane count
  chk_default_mode: assert property (!mode_override_i && clk_en_i
    |=> active_mode_o == LANE_MODE) else $error("mode not lane count");
  // a stalled beat is held unchanged
  chk_data_hold: assert property (m_axis_tvalid_o && !m_axis_tready_i
    |=> $stable(m_axis_tdata_o) && m_axis_tvalid_o) else $error("data dropped");
  // twelve-bit video in sixteen-bit fields: the top bits carry the value
  chk_msb_align: assert property (clk_en_i && take && video_depth_i == 5'h0c
    && MAX_COMPONENT_BITS == 16 && mode_sel != '0
    |=> m_axis_tdata_o[15:4] == $past(in_data_i[11:0])) else $error("component not aligned");
  // the same case leaves the bits below the value at zero
  chk_padding_zero: assert property (clk_en_i && take && video_depth_i == 5'h0c
    && MAX_COMPONENT_BITS == 16 |=> m_axis_tdata_o[3:0] == 4'h0)
    else $error("padding not zero");
  // a long-blank reduced blanking line is recognised
  chk_rb_detect: assert property (clk_en_i && horizontal_blank_pixels_i == 16'h00a0
    && horizontal_total_pixels_i == 16'h03e8 && horizontal_active_pixels_i == 16'h0348
    |=> reduced_blanking_o) else $error("reduced blanking missed");

  // ----------------------------------------
  // covers for the main scenarios
  // ----------------------------------------
  // each cover marks a path the bench must reach
  cov_one_pixel: cover property (take && mode_sel == rvpp_pkg::MODE_ONE);
  cov_two_pixel: cover property (take && mode_sel == rvpp_pkg::MODE_TWO);
  cov_four_pixel: cover property (take && mode_sel == rvpp_pkg::MODE_FOUR);
  cov_flush: cover property (line_reset_o);

endmodule // rvpp_packer

// ---- verification/rvpp_sink_model.sv ----
// downstream video sink model with a stall control
`timescale 1ns/1ns
module rvpp_sink_model (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // stream handshake
  input wire logic tvalid_i,
  input wire logic stall_i,
  output logic tready_o,
  // accepted beat count
  output logic [15:0] beats_o
);
  // ready follows stall one edge late, like registered user logic
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tready_o <= 1'b0;
      beats_o <= 16'h0;
    end else begin
      tready_o <= !stall_i;
      if (tvalid_i && tready_o) beats_o <= beats_o + 16'h1; // count handshakes
    end
  end
endmodule // rvpp_sink_model

// ---- verification/rvpp_packer_tb.sv ----
// self-checking bench for the pixel packer
`timescale 1ns/1ns
module rvpp_packer_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic core_clk_i = 0, rst_n_i = 0, ovr = 0, lrd = 0, vld = 0, sof = 0, eol = 0, stall = 0;
  logic [2:0] pmode = 3'h4, amode;
  logic [4:0] dep = 5'h10;
  logic [15:0] ha = 16'h0, hb = 16'h0, ht = 16'h0, beats;
  logic [191:0] din = '0, dout;
  logic rdy, tv, tu, tl, trdy, rb, lr;
  int errors = 0, checks_done = 0;
  rvpp_packer uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
    .mode_override_i(ovr), .pixels_per_clock_i(pmode), .video_depth_i(dep),
    .line_reset_disable_i(lrd), .horizontal_active_pixels_i(ha),
    .horizontal_blank_pixels_i(hb), .horizontal_total_pixels_i(ht), .in_data_i(din),
    .in_valid_i(vld), .in_sof_i(sof), .in_eol_i(eol), .in_ready_o(rdy),
    .m_axis_tdata_o(dout), .m_axis_tvalid_o(tv), .m_axis_tuser_o(tu), .m_axis_tlast_o(tl),
    .m_axis_tready_i(trdy), .active_mode_o(amode), .reduced_blanking_o(rb),
    .line_reset_o(lr));
  rvpp_sink_model sink (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .tvalid_i(tv),
    .stall_i(stall), .tready_o(trdy), .beats_o(beats));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial forever #50 core_clk_i = ~core_clk_i;
  // raw input bus, or packed bus when pk is set
  function automatic logic [191:0] mk(input int m, d, b, input bit pk);
    logic [191:0] r;
    logic [15:0] v;
    r = '0;
    for (int s = 0; s < 4; s++) for (int c = 0; c < 3; c++) begin
      v = 16'((b + s * 37 + c * 11) & ((1 << d) - 1));
      if (!pk) r[s*48+c*16+:16] = v;
      else if (s < m) r[s*48+c*16+:16] = v << (16 - d);
    end
    return r;
  endfunction
  task automatic chk(input logic [199:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // drive one beat, hold it to the taking edge, drop valid just after it
  task automatic send(input logic [191:0] d, input logic s, e);
    int n;
    n = 0;
    @(posedge core_clk_i);
    #1 din = d;
    sof = s;
    eol = e;
    vld = 1;
    while (rdy !== 1'b1 && n < 20) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    if (n >= 20) chk(rdy, 1'b1);
    @(posedge core_clk_i);
    #1 vld = 0;
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  int md[4] = '{1, 2, 4, 1};
  int dp[4] = '{12, 10, 6, 8};
  initial begin
    repeat (8) @(posedge core_clk_i);
    #1 rst_n_i = 1;
    send(mk(4, 16, 5, 0), 1, 0);
    chk({tu, tl, dout}, {2'b10, mk(4, 16, 5, 1)});
    chk(amode, 4);
    ovr = 1;
    for (int i = 0; i < 4; i++) begin
      pmode = 3'(md[i]);
      dep = 5'(dp[i]);
      send(mk(md[i], dp[i], i, 0), 0, 0);
      chk(dout, mk(md[i], dp[i], i, 1));
      chk(amode, md[i]);
    end
    stall = 1;
    send(mk(1, 8, 9, 0), 0, 0);
    repeat (3) @(posedge core_clk_i);
    #1 chk({tv, dout}, {1'b1, mk(1, 8, 9, 1)});
    stall = 0;
    ha = 16'h0348;
    hb = 16'h00a0;
    ht = 16'h03e8;
    repeat (3) @(posedge core_clk_i);
    #1 chk({rb, beats}, {1'b1, 16'h6});
    send(mk(1, 8, 2, 0), 1, 0);
    send(mk(1, 8, 3, 0), 0, 1);
    chk({lr, rdy, tl, tu}, 4'b1010);
    lrd = 1;
    pmode = 3'h4;
    ht = 16'h02bc;
    send(mk(4, 8, 4, 0), 1, 0);
    send(mk(4, 8, 6, 0), 0, 1);
    chk({lr, rdy, tl, tu}, 4'b0110);
    chk({rb, dout}, {1'b0, mk(4, 8, 6, 1)});
    stop_test();
  end
  // watchdog at 4000 cycles, well beyond the few dozen cycles the tests need
  initial begin
    #400000;
    errors++;
    stop_test();
  end
endmodule // rvpp_packer_tb
